/* File: pee_map.svh */
// timing and field constants for the parallel eeprom host controller
// Contract
// - erase needs high voltage gate, 10 ms
// - same page bits on every load edge
// - gate high while strobe and chip low
// - next byte within 150 us window
// - protected write carries 1 to 64 bytes
// - page bits constant after lock code
// - keep one address for status reads
// - done only when toggle flag stops; host also answers, with timeout flag set, when the program timer runs out
// - three-byte code precedes each locked write
`ifndef PEE_MAP_SVH
`define PEE_MAP_SVH
// ************************************************
// timing
// ************************************************
`define PEE_CLK_MHZ 200
`define PEE_WINDOW_US 150
`define PEE_WINDOW_CYC ((`PEE_WINDOW_US * `PEE_CLK_MHZ))
`define PEE_PROG_MS 10
`define PEE_PROG_CYC ((`PEE_PROG_MS * 1000 * `PEE_CLK_MHZ))
`define PEE_ERASE_MS 10
`define PEE_ERASE_CYC ((`PEE_ERASE_MS * 1000 * `PEE_CLK_MHZ))
`define PEE_SETUP_US 5
`define PEE_SETUP_CYC ((`PEE_SETUP_US * `PEE_CLK_MHZ))
// strobe low 100 ns, high 50 ns, data setup 50 ns, gate low pulse 150 ns
`define PEE_PULSE_NS 100
`define PEE_PULSE_CYC ((`PEE_PULSE_NS * `PEE_CLK_MHZ + 999) / 1000)
`define PEE_READ_NS 150
`define PEE_READ_CYC ((`PEE_READ_NS * `PEE_CLK_MHZ + 999) / 1000)
// ************************************************
// fields and unlock code
// ************************************************
`define PEE_ADDR_W 13
`define PEE_PAGE_LSB 6
`define PEE_PAGE_BYTES 64
`define PEE_TOGGLE_BIT 6
`define PEE_POLL_BIT 7
`define PEE_CODE_A0 13'h1555
`define PEE_CODE_D0 8'haa
`define PEE_CODE_A1 13'h0aaa
`define PEE_CODE_D1 8'h55
`define PEE_CODE_A2 13'h1555
`define PEE_CODE_D2 8'ha0
`endif

/* File: pee_pkg.sv */
// types for the parallel eeprom host controller
package pee_pkg;
  typedef enum logic [1:0] {
    PEE_OP_READ,
    PEE_OP_WRITE,
    PEE_OP_ERASE
  } pee_op_e;
  typedef enum logic [3:0] {
    PEE_ST_IDLE,
    PEE_ST_CODE,
    PEE_ST_SETUP,
    PEE_ST_LOW,
    PEE_ST_HIGH,
    PEE_ST_NEXT,
    PEE_ST_READ,
    PEE_ST_POLL,
    PEE_ST_ERASE,
    PEE_ST_HOLD
  } pee_state_e;
endpackage

/* File: pee_cyc_if.sv */
// strobe request/answer between sequencer and pin cycler
`timescale 1ns/100ps
interface pee_cyc_if;
  logic start;
  logic rd;
  logic [12:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output start, output rd, output addr, output wdata, input done, input rdata);
  modport cyc (input start, input rd, input addr, input wdata, output done, output rdata);
endinterface

/* File: pee_pin_cycler.sv */
// one bus cycle on the eeprom pins: read or byte load
`timescale 1ns/100ps
`include "pee_map.svh"
module pee_pin_cycler (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  pee_cyc_if.cyc cyc,
  input wire logic [7:0] data_sync_in,
  output logic cs_n_out,
  output logic gate_n_out,
  output logic strobe_n_out,
  output logic [12:0] addr_out,
  output logic [7:0] data_out,
  output logic data_oe_out
);
  import pee_pkg::*;
  typedef enum logic [1:0] {PC_IDLE, PC_LOW, PC_HIGH} pee_pc_e;
  localparam logic [7:0] LOW_CYC = 8'(`PEE_READ_CYC);
  localparam logic [7:0] HIGH_CYC = 8'(`PEE_PULSE_CYC);
  pee_pc_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic rd_q, rd_d;
  logic cs_q, cs_d, gate_q, gate_d, stb_q, stb_d, oe_q, oe_d, done_q, done_d;
  logic [12:0] addr_q, addr_d;
  logic [7:0] wd_q, wd_d, rdat_q, rdat_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    cs_d = cs_q;
    gate_d = gate_q;
    stb_d = stb_q;
    oe_d = oe_q;
    addr_d = addr_q;
    wd_d = wd_q;
    rdat_d = rdat_q;
    done_d = 1'b0;
    case (st_q)
      PC_IDLE: begin
        if (cyc.start) begin
          rd_d = cyc.rd;
          addr_d = cyc.addr;
          wd_d = cyc.wdata;
          cs_d = 1'b0;
          cnt_d = LOW_CYC;
          st_d = PC_LOW;
          if (cyc.rd) begin
            gate_d = 1'b0;
            oe_d = 1'b0;
          end else begin
            gate_d = 1'b1;
            stb_d = 1'b0;
            oe_d = 1'b1;
          end
        end
      end
      PC_LOW: begin
        if (cnt_q == 8'h00) begin
          if (rd_q) begin
            rdat_d = data_sync_in;
          end
          // gate and chip rise together so each read is one toggle strobe
          gate_d = 1'b1;
          stb_d = 1'b1;
          cs_d = 1'b1;
          cnt_d = HIGH_CYC;
          st_d = PC_HIGH;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: begin
        if (cnt_q == 8'h00) begin
          oe_d = 1'b0;
          done_d = 1'b1;
          st_d = PC_IDLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_q <= PC_IDLE;
      cnt_q <= 8'h00;
      rd_q <= 1'b0;
      cs_q <= 1'b1;
      gate_q <= 1'b1;
      stb_q <= 1'b1;
      oe_q <= 1'b0;
      addr_q <= 13'h0000;
      wd_q <= 8'h00;
      rdat_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      cs_q <= cs_d;
      gate_q <= gate_d;
      stb_q <= stb_d;
      oe_q <= oe_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      rdat_q <= rdat_d;
      done_q <= done_d;
    end
  end

  assign cs_n_out = cs_q;
  assign gate_n_out = gate_q;
  assign strobe_n_out = stb_q;
  assign addr_out = addr_q;
  assign data_out = wd_q;
  assign data_oe_out = oe_q;
  assign cyc.done = done_q;
  assign cyc.rdata = rdat_q;
endmodule // pee_pin_cycler

/* File: pee_host.sv */
// host controller driving a byte-wide parallel eeprom over its pins
`timescale 1ns/100ps
`include "pee_map.svh"
module pee_host #(
  parameter int PROG_CYC = `PEE_PROG_CYC,
  parameter int ERASE_CYC = `PEE_ERASE_CYC,
  parameter int SETUP_CYC = `PEE_SETUP_CYC,
  parameter int WINDOW_CYC = `PEE_WINDOW_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire pee_pkg::pee_op_e req_op_in,
  input wire logic req_locked_in,
  input wire logic [12:0] req_addr_in,
  input wire logic [7:0] req_data_in,
  input wire logic req_last_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic rsp_timeout_out,
  output logic ee_cs_n_out,
  output logic ee_gate_n_out,
  output logic ee_strobe_n_out,
  output logic ee_gate_hv_out,
  output logic [12:0] ee_addr_out,
  output logic [7:0] ee_data_out,
  output logic ee_data_oe_out,
  input wire logic [7:0] ee_data_in
);
  import pee_pkg::*;
  // ************************************************
  // pin input synchroniser
  // ************************************************
  logic [7:0] s1_q, s2_q, s3_q, dat_q, dat_d;
  always_comb begin
    dat_d = dat_q;
    if (s2_q == s3_q) begin
      dat_d = s3_q;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
      dat_q <= 8'h00;
    end else begin
      s1_q <= ee_data_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dat_q <= dat_d;
    end
  end
  // ************************************************
  // sequencer
  // ************************************************
  pee_cyc_if cyc ();
  logic cs_n, gate_n, stb_n, oe;
  logic [12:0] pa;
  logic [7:0] pd;
  pee_pin_cycler u_cyc (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .cyc(cyc.cyc),
    .data_sync_in(dat_q),
    .cs_n_out(cs_n),
    .gate_n_out(gate_n),
    .strobe_n_out(stb_n),
    .addr_out(pa),
    .data_out(pd),
    .data_oe_out(oe)
  );
  function automatic logic [12:0] code_addr(input logic [1:0] i);
    code_addr = (i == 2'd0) ? `PEE_CODE_A0 : (i == 2'd1) ? `PEE_CODE_A1 : `PEE_CODE_A2;
  endfunction
  function automatic logic [7:0] code_data(input logic [1:0] i);
    code_data = (i == 2'd0) ? `PEE_CODE_D0 : (i == 2'd1) ? `PEE_CODE_D1 : `PEE_CODE_D2;
  endfunction
  pee_state_e st_q, st_d;
  logic [31:0] tmr_q, tmr_d, win_q, win_d;
  logic [1:0] ci_q, ci_d;
  logic [12:0] a_q, a_d, last_a_q, last_a_d;
  logic [7:0] d_q, d_d, prev_q, prev_d;
  logic [6:0] nb_q, nb_d;
  logic lck_q, lck_d, last_q, last_d, fst_q, fst_d;
  logic rdy_q, rdy_d, rv_q, rv_d, to_q, to_d, hv_q, hv_d, hcs_q, hcs_d, hst_q, hst_d;
  logic [7:0] rsp_q, rsp_d;
  logic cstart, crd;
  logic [12:0] caddr;
  logic [7:0] cwd;
  logic pend_q, pend_d;
  always_comb begin
    st_d = st_q;
    {tmr_d, win_d, ci_d, a_d, last_a_d, d_d, prev_d, nb_d} =
      {tmr_q, win_q, ci_q, a_q, last_a_q, d_q, prev_q, nb_q};
    {lck_d, last_d, fst_d, hv_d, hcs_d, hst_d, pend_d, rsp_d} =
      {lck_q, last_q, fst_q, hv_q, hcs_q, hst_q, pend_q, rsp_q};
    {rdy_d, rv_d, to_d, cstart, crd} = 5'h00;
    caddr = a_q;
    cwd = d_q;
    if (win_q != 0) begin
      win_d = win_q - 1;
    end
    case (st_q)
      PEE_ST_IDLE: begin
        rdy_d = 1'b1;
        if (req_valid_in && rdy_q) begin
          rdy_d = 1'b0;
          a_d = req_addr_in;
          d_d = req_data_in;
          last_d = req_last_in;
          lck_d = req_locked_in;
          nb_d = 7'h00;
          ci_d = 2'd0;
          if (req_op_in == PEE_OP_READ) begin
            st_d = PEE_ST_READ;
          end else if (req_op_in == PEE_OP_ERASE) begin
            hcs_d = 1'b1;
            tmr_d = SETUP_CYC;
            st_d = PEE_ST_SETUP;
          end else begin
            st_d = req_locked_in ? PEE_ST_CODE : PEE_ST_LOW;
          end
        end
      end
      PEE_ST_CODE: begin
        cstart = 1'b1;
        caddr = code_addr(ci_q);
        cwd = code_data(ci_q);
        win_d = WINDOW_CYC;
        st_d = PEE_ST_HIGH;
      end
      PEE_ST_LOW: begin
        // caller keeps page bits fixed; a stray page ends the load early
        cstart = 1'b1;
        win_d = WINDOW_CYC;
        last_a_d = a_q;
        nb_d = nb_q + 7'h01;
        st_d = PEE_ST_HIGH;
      end
      PEE_ST_HIGH: begin
        if (cyc.done) begin
          if (ci_q != 2'd3 && lck_q) begin
            ci_d = ci_q + 2'd1;
            st_d = (ci_q == 2'd2) ? PEE_ST_LOW : PEE_ST_CODE;
            if (ci_q == 2'd2) begin
              ci_d = 2'd3;
            end
          end else if (last_q || nb_q == 7'(`PEE_PAGE_BYTES)) begin
            fst_d = 1'b1;
            tmr_d = PROG_CYC;
            st_d = PEE_ST_POLL;
          end else begin
            rdy_d = 1'b1;
            st_d = PEE_ST_NEXT;
          end
        end
      end
      PEE_ST_NEXT: begin
        rdy_d = 1'b1;
        if (req_valid_in && rdy_q && req_op_in == PEE_OP_WRITE &&
            req_addr_in[12:`PEE_PAGE_LSB] == last_a_q[12:`PEE_PAGE_LSB]) begin
          rdy_d = 1'b0;
          a_d = req_addr_in;
          d_d = req_data_in;
          last_d = req_last_in;
          st_d = PEE_ST_LOW;
        end else if (win_q == 0 || (req_valid_in && rdy_q)) begin
          // window gone or another request: device programs what it latched
          rdy_d = 1'b0;
          fst_d = 1'b1;
          tmr_d = PROG_CYC;
          st_d = PEE_ST_POLL;
        end
      end
      PEE_ST_POLL: begin
        // status reads at one address until bit six stops changing
        // one read in flight at a time, so no stray cycle outlives the poll
        if (!pend_q) begin
          cstart = 1'b1;
          crd = 1'b1;
          caddr = last_a_q;
          pend_d = 1'b1;
        end
        if (tmr_q != 0) begin
          tmr_d = tmr_q - 1;
        end
        if (cyc.done) begin
          pend_d = 1'b0;
          prev_d = cyc.rdata;
          fst_d = 1'b0;
          if (!fst_q && cyc.rdata[`PEE_TOGGLE_BIT] == prev_q[`PEE_TOGGLE_BIT]) begin
            rv_d = 1'b1;
            rsp_d = cyc.rdata;
            st_d = PEE_ST_IDLE;
          end else if (tmr_q == 0) begin
            rv_d = 1'b1;
            to_d = 1'b1;
            rsp_d = cyc.rdata;
            st_d = PEE_ST_IDLE;
          end
        end
      end
      PEE_ST_READ: begin
        cstart = 1'b1;
        crd = 1'b1;
        st_d = PEE_ST_HOLD;
      end
      PEE_ST_HOLD: begin
        if (cyc.done) begin
          rv_d = 1'b1;
          rsp_d = cyc.rdata;
          st_d = PEE_ST_IDLE;
        end
      end
      PEE_ST_SETUP: begin
        if (tmr_q == 0) begin
          if (hst_q) begin
            hcs_d = 1'b0;
            hst_d = 1'b0;
            rv_d = 1'b1;
            st_d = PEE_ST_IDLE;
          end else begin
            hst_d = 1'b1;
            hv_d = 1'b1;
            tmr_d = ERASE_CYC;
            st_d = PEE_ST_ERASE;
          end
        end else begin
          tmr_d = tmr_q - 1;
        end
      end
      default: begin
        if (tmr_q == 0) begin
          hv_d = 1'b0;
          tmr_d = SETUP_CYC;
          st_d = PEE_ST_SETUP;
        end else begin
          tmr_d = tmr_q - 1;
        end
      end
    endcase
  end

  assign cyc.start = cstart;
  assign cyc.rd = crd;
  assign cyc.addr = caddr;
  assign cyc.wdata = cwd;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_q <= PEE_ST_IDLE;
      {tmr_q, win_q} <= 64'h0;
      {ci_q, a_q, last_a_q, d_q, prev_q, nb_q} <= 51'h0;
      {lck_q, last_q, fst_q, rdy_q, rv_q, to_q, hv_q, hcs_q, hst_q, pend_q} <= 10'h000;
      rsp_q <= 8'h00;
    end else begin
      st_q <= st_d;
      {tmr_q, win_q} <= {tmr_d, win_d};
      {ci_q, a_q, last_a_q, d_q, prev_q, nb_q} <= {ci_d, a_d, last_a_d, d_d, prev_d, nb_d};
      {lck_q, last_q, fst_q, rdy_q, rv_q, to_q, hv_q, hcs_q, hst_q, pend_q} <=
        {lck_d, last_d, fst_d, rdy_d, rv_d, to_d, hv_d, hcs_d, hst_d, pend_d};
      rsp_q <= rsp_d;
    end
  end
  // ************************************************
  // pin merge: erase holds chip and strobe low itself
  // ************************************************
  logic pcs_q, pgate_q, pstb_q, poe_q;
  logic [12:0] paddr_q;
  logic [7:0] pdat_q;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      {pcs_q, pgate_q, pstb_q, poe_q} <= 4'he;
      {paddr_q, pdat_q} <= 21'h00000;
    end else begin
      pcs_q <= cs_n & ~hcs_q;
      pgate_q <= gate_n;
      pstb_q <= stb_n & ~hcs_q;
      poe_q <= oe & ~hcs_q;
      {paddr_q, pdat_q} <= {pa, pd};
    end
  end
  assign ee_cs_n_out = pcs_q;
  assign ee_gate_n_out = pgate_q;
  assign ee_strobe_n_out = pstb_q;
  assign ee_gate_hv_out = hv_q;
  assign ee_addr_out = paddr_q;
  assign ee_data_out = pdat_q;
  assign ee_data_oe_out = poe_q;
  assign req_ready_out = rdy_q;
  assign rsp_valid_out = rv_q;
  assign rsp_data_out = rsp_q;
  assign rsp_timeout_out = to_q;
endmodule // pee_host

/* File: pee_monitor.sv */
// pin and handshake assertions for the eeprom host controller
`timescale 1ns/100ps
module pee_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire pee_pkg::pee_op_e req_op_in,
  input wire logic req_ready_out,
  input wire logic rsp_valid_out,
  input wire logic rsp_timeout_out,
  input wire logic ee_cs_n_out,
  input wire logic ee_gate_n_out,
  input wire logic ee_strobe_n_out,
  input wire logic ee_gate_hv_out,
  input wire logic [12:0] ee_addr_out,
  input wire logic [7:0] ee_data_out,
  input wire logic ee_data_oe_out
);
  import pee_pkg::*;
  // ****************
  // properties
  // ****************
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_read_taken;
    req_valid_in && req_ready_out && req_op_in == PEE_OP_READ;
  endsequence
  sequence s_erase_held;
    ee_gate_hv_out && !ee_cs_n_out && !ee_strobe_n_out;
  endsequence
  gate_in_write_a: assert property (
    !ee_cs_n_out && !ee_strobe_n_out && !ee_gate_hv_out |-> ee_gate_n_out)
    else $error("gate low inside a write strobe");
  read_no_drive_a: assert property (!ee_gate_n_out |-> !ee_data_oe_out)
    else $error("host drives data while gate low");
  read_no_strobe_a: assert property (!ee_gate_n_out |-> ee_strobe_n_out)
    else $error("strobe low while gate low");
  hv_select_a: assert property (ee_gate_hv_out |-> s_erase_held)
    else $error("high voltage without select and strobe");
  erase_hold_a: assert property ($rose(ee_gate_hv_out) |-> s_erase_held [*8])
    else $error("erase voltage dropped early");
  load_stable_a: assert property (
    !ee_strobe_n_out && !ee_cs_n_out && !$past(ee_strobe_n_out)
    |-> $stable(ee_addr_out) && $stable(ee_data_out))
    else $error("address or data moved under strobe");
  strobe_width_a: assert property ($fell(ee_strobe_n_out) |-> (!ee_strobe_n_out) [*8])
    else $error("write strobe too short");
  read_answer_a: assert property (s_read_taken |-> ##[20:200] rsp_valid_out)
    else $error("read not answered");
  rsp_pulse_a: assert property (rsp_valid_out |=> !rsp_valid_out)
    else $error("response longer than one cycle");
  timeout_flag_a: assert property (rsp_timeout_out |-> rsp_valid_out)
    else $error("timeout flag without response");
endmodule // pee_monitor

bind pee_host pee_monitor u_mon (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
  .req_op_in(req_op_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
  .rsp_timeout_out(rsp_timeout_out), .ee_cs_n_out(ee_cs_n_out),
  .ee_gate_n_out(ee_gate_n_out), .ee_strobe_n_out(ee_strobe_n_out),
  .ee_gate_hv_out(ee_gate_hv_out), .ee_addr_out(ee_addr_out),
  .ee_data_out(ee_data_out), .ee_data_oe_out(ee_data_oe_out)
);

/* File: pee_eeprom_model.sv */
// behavioural byte-wide eeprom answering the host pins
`timescale 1ns/100ps
`include "pee_map.svh"
module pee_eeprom_model #(
  parameter int PROG = 600,
  parameter int WIN = 800,
  parameter int ERASE = 400,
  parameter bit LOCKED = 1
) (
  input wire logic clk_in,
  input wire logic cs_n_in,
  input wire logic gate_n_in,
  input wire logic strobe_n_in,
  input wire logic hv_in,
  input wire logic [12:0] addr_in,
  input wire logic [7:0] host_data_in,
  input wire logic host_oe_in,
  output logic [7:0] pin_data_out
);
  // ****************
  // storage and status
  // ****************
  logic [7:0] mem [0:8191];
  logic [7:0] last_q, float_q, rd_v;
  logic [12:0] last_a_q;
  logic [20:0] code_v;
  logic [1:0] code_q;
  logic tog_q, prev_s_q, prev_c_q, prev_r_q, load_q, ers_q;
  int busy_q, win_q, hv_q;
  wire rd = !cs_n_in && !gate_n_in && strobe_n_in;
  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ 8'h5a;
    {tog_q, prev_r_q, load_q, ers_q, code_q, busy_q, win_q, hv_q} = '0;
    {last_q, last_a_q, float_q, prev_s_q, prev_c_q} = 31'h3;
  end
  always_comb begin
    code_v = code_q == 2'h0 ? {`PEE_CODE_A0, `PEE_CODE_D0} :
      code_q == 2'h1 ? {`PEE_CODE_A1, `PEE_CODE_D1} : {`PEE_CODE_A2, `PEE_CODE_D2};
    rd_v = mem[addr_in];
    if (busy_q > 0) rd_v = {addr_in == last_a_q ? ~last_q[7] : rd_v[7], tog_q, rd_v[5:0]};
    // no pull on the data lines: a floating bus shows a changing pattern
    pin_data_out = host_oe_in ? host_data_in : rd ? rd_v : ~float_q;
  end
  always @(posedge clk_in) begin
    float_q <= pin_data_out;
    prev_s_q <= strobe_n_in;
    prev_c_q <= cs_n_in;
    prev_r_q <= rd;
    if (rd && !prev_r_q && busy_q > 0) tog_q <= !tog_q;
    if (busy_q == 1) code_q <= 2'h0;
    if (busy_q > 0) busy_q <= busy_q - 1;
    // a read also closes the load, so the host never polls an idle page
    if (load_q && (win_q >= WIN || rd)) begin
      load_q <= 1'b0;
      busy_q <= PROG;
    end else if (load_q) win_q <= win_q + 1;
    // chip and strobe may rise together: latch on the strobe edge ending a low pair
    if (strobe_n_in && !prev_s_q && !prev_c_q && gate_n_in && !hv_in && !ers_q &&
        busy_q == 0) begin
      load_q <= 1'b1;
      win_q <= 0;
      if (code_q < 2'h3 && {addr_in, host_data_in} == code_v) code_q <= code_q + 2'h1;
      else if (!LOCKED || code_q == 2'h3) begin
        mem[addr_in] <= host_data_in;
        last_q <= host_data_in;
        last_a_q <= addr_in;
      end
    end
    if (strobe_n_in) ers_q <= 1'b0;
    if (hv_in && !cs_n_in && !strobe_n_in) hv_q <= hv_q + 1;
    else if (hv_q > 0) begin
      if (hv_q >= ERASE) for (int i = 0; i < 8192; i++) mem[i] <= 8'hff;
      hv_q <= 0;
      ers_q <= 1'b1;
    end
  end
endmodule // pee_eeprom_model

/* File: testbench.sv */
// self-checking bench for the eeprom host controller
`timescale 1ns/100ps
module testbench;
  import pee_pkg::*;
  typedef struct {pee_op_e op; logic lk; logic [12:0] a; logic [7:0] d; logic last;
    logic [7:0] e;} pee_row_s;
  logic sys_clk_in = 0, rst_in = 1, req_valid_in = 0, req_locked_in = 0, req_last_in = 0;
  logic req_ready_out, rsp_valid_out, rsp_timeout_out, ee_cs_n_out, ee_gate_n_out;
  logic ee_strobe_n_out, ee_gate_hv_out, ee_data_oe_out;
  pee_op_e req_op_in = PEE_OP_READ;
  logic [12:0] req_addr_in = 0, ee_addr_out;
  logic [7:0] req_data_in = 0, rsp_data_out, ee_data_out, ee_data_in;
  int err_total = 0, samples_checked = 0, cyc = 0, n;
  pee_row_s rows [11] = '{
    '{PEE_OP_WRITE, 1'b1, 13'h0040, 8'h3c, 1'b1, 8'h3c},
    '{PEE_OP_READ, 1'b0, 13'h0040, 8'h00, 1'b0, 8'h3c},
    '{PEE_OP_WRITE, 1'b0, 13'h0200, 8'h11, 1'b1, 8'h5a},
    '{PEE_OP_READ, 1'b0, 13'h0200, 8'h00, 1'b0, 8'h5a},
    '{PEE_OP_READ, 1'b0, 13'h1fff, 8'h00, 1'b0, 8'ha5},
    '{PEE_OP_WRITE, 1'b1, 13'h0080, 8'h01, 1'b0, 8'h00},
    '{PEE_OP_WRITE, 1'b0, 13'h0081, 8'h02, 1'b0, 8'h00},
    '{PEE_OP_WRITE, 1'b0, 13'h00bf, 8'h03, 1'b1, 8'h03},
    '{PEE_OP_READ, 1'b0, 13'h0081, 8'h00, 1'b0, 8'h02},
    '{PEE_OP_READ, 1'b0, 13'h00bf, 8'h00, 1'b0, 8'h03},
    '{PEE_OP_READ, 1'b0, 13'h0082, 8'h00, 1'b0, 8'hd8}
  };
  always #2.5 sys_clk_in = ~sys_clk_in;
  pee_host #(.PROG_CYC(2000), .ERASE_CYC(500), .SETUP_CYC(20), .WINDOW_CYC(400)) dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_op_in(req_op_in), .req_locked_in(req_locked_in), .req_addr_in(req_addr_in),
    .req_data_in(req_data_in), .req_last_in(req_last_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
    .rsp_timeout_out(rsp_timeout_out), .ee_cs_n_out(ee_cs_n_out),
    .ee_gate_n_out(ee_gate_n_out), .ee_strobe_n_out(ee_strobe_n_out),
    .ee_gate_hv_out(ee_gate_hv_out), .ee_addr_out(ee_addr_out), .ee_data_out(ee_data_out),
    .ee_data_oe_out(ee_data_oe_out), .ee_data_in(ee_data_in));
  pee_eeprom_model mem_model (.clk_in(sys_clk_in), .cs_n_in(ee_cs_n_out),
    .gate_n_in(ee_gate_n_out), .strobe_n_in(ee_strobe_n_out), .hv_in(ee_gate_hv_out),
    .addr_in(ee_addr_out), .host_data_in(ee_data_out), .host_oe_in(ee_data_oe_out),
    .pin_data_out(ee_data_in));
  // ****************
  // tasks
  // ****************
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %b got %b", nm, e, g);
    end
  endtask
  // ready is read in the edge's own time step, before the design updates it
  task automatic send(input pee_row_s r);
    @(negedge sys_clk_in);
    {req_valid_in, req_locked_in} = {1'b1, r.lk};
    req_op_in = r.op;
    {req_addr_in, req_data_in, req_last_in} = {r.a, r.d, r.last};
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 9000);
    chk1("request taken", 1'b1, n < 9000);
    @(negedge sys_clk_in);
    req_valid_in = 0;
  endtask
  task automatic check(input pee_row_s r);
    n = 0;
    do begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end while (rsp_valid_out !== 1'b1 && n < 9000);
    chk1("response seen", 1'b1, n < 9000);
    if (r.op == PEE_OP_READ) chk8("read data", r.e, rsp_data_out);
    else chk1("timeout flag", 1'b0, rsp_timeout_out);
    if (r.op == PEE_OP_WRITE) chk8("final status", r.e, rsp_data_out);
  endtask
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      $display("ERROR run time limit expected 40000 got %0d", cyc);
      results();
    end
  end
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (12) @(negedge sys_clk_in);
    chk1("strobe in reset", 1'b1, ee_strobe_n_out);
    chk1("ready in reset", 1'b0, req_ready_out);
    chk1("drive in reset", 1'b0, ee_data_oe_out);
    chk1("hv in reset", 1'b0, ee_gate_hv_out);
    rst_in = 0;
    $display("reset test done");
    foreach (rows[i]) begin
      send(rows[i]);
      if (rows[i].op != PEE_OP_WRITE || rows[i].last) check(rows[i]);
      $display("row %0d done", i);
    end
    send('{PEE_OP_ERASE, 1'b0, 13'h0000, 8'h00, 1'b0, 8'h00});
    check('{PEE_OP_ERASE, 1'b0, 13'h0000, 8'h00, 1'b0, 8'h00});
    send('{PEE_OP_READ, 1'b0, 13'h0040, 8'h00, 1'b0, 8'hff});
    check('{PEE_OP_READ, 1'b0, 13'h0040, 8'h00, 1'b0, 8'hff});
    $display("erase test done");
    // no last byte: only the load window can close this page
    send('{PEE_OP_WRITE, 1'b1, 13'h0300, 8'h77, 1'b0, 8'h00});
    check('{PEE_OP_WRITE, 1'b1, 13'h0300, 8'h77, 1'b0, 8'h77});
    send('{PEE_OP_READ, 1'b0, 13'h0300, 8'h00, 1'b0, 8'h77});
    check('{PEE_OP_READ, 1'b0, 13'h0300, 8'h00, 1'b0, 8'h77});
    $display("window test done");
    results();
  end
endmodule // testbench
